// ---- bench/odf_front_end_assertions.sv ----
// port checker for the octal converter serial front end
`timescale 1ns/1ps
module odf_front_end_chk (
  input logic         core_clk_i,
  input logic         sys_rst_i,
  input logic         load_dac_n_i,
  input logic         clear_n_i,
  input logic [127:0] dac_code_o,
  input logic         power_down_o,
  input logic         s_axi_awvalid,
  input logic         s_axi_awready,
  input logic         s_axi_wvalid,
  input logic         s_axi_wready,
  input logic [1:0]   s_axi_bresp,
  input logic         s_axi_bvalid,
  input logic         s_axi_bready,
  input logic         s_axi_arvalid,
  input logic         s_axi_arready,
  input logic [31:0]  s_axi_rdata,
  input logic         s_axi_rvalid,
  input logic         s_axi_rready
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // reset is not a disable here, it is the cause under test
  reset_zero_a: assert property (
    disable iff (1'b0) sys_rst_i |=> dac_code_o == 0 && !power_down_o)
    else $error("outputs not cleared by reset");
  // six cycles covers the two stage synchroniser on load
  load_hold_a: assert property (
    (load_dac_n_i && clear_n_i) [*6] |-> $stable(dac_code_o))
    else $error("output code moved while load high");
  clear_zero_a: assert property (
    (!clear_n_i) [*8] |-> dac_code_o == 0)
    else $error("codes not zero while clear low");
  pd_keeps_codes_a: assert property (
    $rose(power_down_o) |-> $stable(dac_code_o))
    else $error("power-down word changed a code");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  cov_pd: cover property ($rose(power_down_o));
  cov_clear: cover property ((!clear_n_i) [*8]);
  cov_hold: cover property ((load_dac_n_i && clear_n_i) [*6]);
endmodule

bind odf_front_end odf_front_end_chk chk_u (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .load_dac_n_i(load_dac_n_i), .clear_n_i(clear_n_i),
  .dac_code_o(dac_code_o), .power_down_o(power_down_o),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ---- bench/odf_front_end_tb.sv ----
// self-checking bench of the serial front end
`timescale 1ns/1ps
module odf_front_end_tb;
  logic         core_clk_i, sys_rst_i, sclk, din, sync_n;
  logic         load_dac_n_i, clear_n_i, frame_ready_o, power_down_o;
  logic [127:0] dac_code_o;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, d;
  logic [1:0]   s_axi_bresp, s_axi_rresp, r;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready, exp_pd;
  logic [15:0]  exp_code [8];
  logic [15:0]  nxt [8];
  int           failures, n_checks, cycles, i;
  integer       seed;

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  odf_host host_u (.core_clk_i(core_clk_i), .sclk_o(sclk), .din_o(din),
    .sync_n_o(sync_n));
  odf_front_end #(.HIGH_RES(1)) dut_u (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .serial_clock_in_i(sclk), .serial_data_in_i(din),
    .frame_sync_n_i(sync_n), .load_dac_n_i(load_dac_n_i),
    .clear_n_i(clear_n_i), .dac_code_o(dac_code_o),
    .power_down_o(power_down_o), .frame_ready_o(frame_ready_o),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  task automatic summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // hang guard, roughly four times the expected run
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("unexpected at %0t: run timed out", $time);
      summarize();
    end
  end

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    begin
      n_checks++;
      if (g !== e) begin
        failures++;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask

  task automatic chk_all;
    int k;
    begin
      for (k = 0; k < 8; k++)
        chk_val({16'h0000, dac_code_o[16*k+:16]}, {16'h0000, exp_code[k]});
      chk_val({31'h0, power_down_o}, {31'h0, exp_pd});
    end
  endtask

  // address and data offered together, each released when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    bit ad, wd;
    begin
      ad = 0;
      wd = 0;
      @(posedge core_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
        @(posedge core_clk_i);
        if (s_axi_awready && !ad) begin
          ad = 1;
          s_axi_awvalid <= 1'b0;
        end
        if (s_axi_wready && !wd) begin
          wd = 1;
          s_axi_wvalid <= 1'b0;
        end
      end
      do @(posedge core_clk_i); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [11:0] a);
    begin
      @(posedge core_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge core_clk_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk_i); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  // ignored top nibble is random; model follows only when ap is set
  task automatic send(input logic [2:0] ch, input logic pd,
                      input logic [15:0] c, input int n, input bit ap);
    begin
      host_u.frame({4'($random(seed)), ch, pd, c}, n);
      if (ap && n == 24) begin
        exp_pd = pd;
        if (!pd) exp_code[ch] = c;
      end
      repeat (8) @(posedge core_clk_i);
    end
  endtask

  initial begin
    seed = 32'h6D7E;
    sys_rst_i = 1'b1;
    load_dac_n_i = 1'b0;
    clear_n_i = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    exp_pd = 1'b0;
    for (i = 0; i < 8; i++) exp_code[i] = 16'h0000;
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk_all();
    for (i = 0; i < 8; i++) begin
      send(i[2:0], 1'b0, 16'($random(seed)), 24, 1);
      chk_all();
    end
    $display("test channels done");
    load_dac_n_i <= 1'b1;
    send(3'h3, 1'b0, 16'hA5C3, 24, 0);
    chk_all();
    load_dac_n_i <= 1'b0;
    exp_code[3] = 16'hA5C3;
    repeat (8) @(posedge core_clk_i);
    chk_all();
    $display("test load hold done");
    send(3'h5, 1'b0, 16'h1234, 10, 1);
    chk_all();
    axi_rd(12'h00C);
    chk_val(d, 32'h1);
    axi_rd(12'h008);
    chk_val(d, 32'h9);
    $display("test abort done");
    send(3'h2, 1'b1, 16'hFFFF, 24, 1);
    chk_all();
    send(3'h2, 1'b0, 16'h8001, 24, 1);
    chk_all();
    for (i = 0; i < 8; i++) begin
      axi_rd(12'h020 + 12'(4 * i));
      chk_val(d, {16'h0000, exp_code[i]});
    end
    axi_rd(12'h100);
    chk_val({30'h0, r}, 32'h2);
    axi_wr(12'h024, 32'h1);
    chk_val({30'h0, r}, 32'h2);
    $display("test power down and registers done");
    // drain hold stalls the far side so the fifo fills and refuses
    axi_wr(12'h000, 32'h1);
    // first eight words wait in the fifo, the ninth is dropped
    for (i = 0; i < 9; i++) begin
      d = 32'($random(seed));
      if (i < 8) nxt[i] = d[15:0];
      send(3'(i % 8), 1'b0, d[15:0], 24, 0);
    end
    chk_val({31'h0, frame_ready_o}, 32'h0);
    chk_all();
    axi_rd(12'h004);
    chk_val({25'h0, d[6:0]}, 32'h28);
    axi_wr(12'h000, 32'h0);
    repeat (24) @(posedge core_clk_i);
    for (i = 0; i < 8; i++) exp_code[i] = nxt[i];
    chk_all();
    axi_wr(12'h004, 32'h20);
    axi_rd(12'h004);
    chk_val(d, 32'h0);
    $display("test fifo full done");
    clear_n_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    clear_n_i <= 1'b1;
    for (i = 0; i < 8; i++) exp_code[i] = 16'h0000;
    chk_all();
    send(3'h1, 1'b0, 16'h5A5A, 24, 1);
    chk_all();
    // soft clear bit acts like the clear pin
    axi_wr(12'h000, 32'h2);
    exp_code[1] = 16'h0000;
    repeat (2) @(posedge core_clk_i);
    chk_all();
    axi_wr(12'h000, 32'h0);
    $display("test clear done");
    summarize();
  end
endmodule

// ---- bench/odf_host.sv ----
// serial master model driving the three wire link
`timescale 1ns/1ps
module odf_host (
  input  logic core_clk_i,
  output logic sclk_o,
  output logic din_o,
  output logic sync_n_o
);
  initial begin
    sclk_o = 1'b0;
    din_o = 1'b0;
    sync_n_o = 1'b1;
  end
  // one frame msb first at 320 ns per bit; n below 24 aborts it
  task automatic frame(input logic [23:0] w, input int n);
    int i;
    begin
      @(posedge core_clk_i);
      sync_n_o <= 1'b0;
      for (i = 23; i > 23 - n; i--) begin
        repeat (4) @(posedge core_clk_i);
        din_o <= w[i];
        sclk_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        sclk_o <= 1'b0;
      end
      repeat (4) @(posedge core_clk_i);
      // clock stands still, data no longer holds the last bit
      sync_n_o <= 1'b1;
      din_o <= ~din_o;
      repeat (4) @(posedge core_clk_i);
    end
  endtask
endmodule

// ---- design/odf_fifo.v ----
// synchronous word fifo with valid/ready on both sides
`timescale 1ns/1ps
module odf_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             core_clk_i,
  input  wire             sys_rst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [AW:0]      level_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg [WIDTH-1:0] out_data;
  wire            push;
  wire            pop;

  // full and empty come straight from the occupancy count
  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign level_o     = count;
  assign out_data_o  = out_data;

  // storage array has no reset, pointers do
  always @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // head word read straight from the array cells, which are flops
  always @* begin
    out_data = mem[rd_ptr];
  end

  // pointer and count bookkeeping
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// ---- design/odf_front_end.v ----
// serial front end of the eight channel converter with AXI4-Lite access
`timescale 1ns/1ps
`include "odf_regs.vh"
module odf_front_end #(
  parameter HIGH_RES = 1
) (
  input  wire                        core_clk_i,
  input  wire                        sys_rst_i,
  // serial pins, asynchronous to core_clk_i
  input  wire                        serial_clock_in_i,
  input  wire                        serial_data_in_i,
  input  wire                        frame_sync_n_i,
  input  wire                        load_dac_n_i,
  input  wire                        clear_n_i,
  // converter side
  output wire [16*`ODF_NUM_CHAN-1:0] dac_code_o,
  output wire                        power_down_o,
  output wire                        frame_ready_o,
  // AXI4-Lite slave
  input  wire [11:0]                 s_axi_awaddr,
  input  wire                        s_axi_awvalid,
  output wire                        s_axi_awready,
  input  wire [31:0]                 s_axi_wdata,
  input  wire [3:0]                  s_axi_wstrb,
  input  wire                        s_axi_wvalid,
  output wire                        s_axi_wready,
  output reg  [1:0]                  s_axi_bresp,
  output reg                         s_axi_bvalid,
  input  wire                        s_axi_bready,
  input  wire [11:0]                 s_axi_araddr,
  input  wire                        s_axi_arvalid,
  output wire                        s_axi_arready,
  output reg  [31:0]                 s_axi_rdata,
  output reg  [1:0]                  s_axi_rresp,
  output reg                         s_axi_rvalid,
  input  wire                        s_axi_rready
);

  localparam FRAME_LEN = HIGH_RES ? `ODF_FRAME_LEN_HI : `ODF_FRAME_LEN_LO;
  localparam CODE_W    = HIGH_RES ? `ODF_CODE_W_HI : `ODF_CODE_W_LO;
  localparam WORD_W    = 1 + `ODF_CHAN_W + 16;
  localparam SYNC_MIN  = `ODF_SYNC_HIGH_CYC;
  // one-hot frame states
  localparam ST_IDLE   = 3'b001;
  localparam ST_SHIFT  = 3'b010;
  localparam ST_DONE   = 3'b100;

  // two-stage synchronisers for every pin
  reg  [4:0] pin_s1;
  reg  [4:0] pin_s2;
  reg        sclk_d;
  wire       sclk_s  = pin_s2[0];
  wire       din_s   = pin_s2[1];
  wire       fs_n_s  = pin_s2[2];
  wire       load_n_s = pin_s2[3];
  wire       clr_n_s = pin_s2[4];
  wire       sclk_fall = sclk_d & ~sclk_s;

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pin_s1 <= 5'h1C;
      pin_s2 <= 5'h1C;
      sclk_d <= 1'b0; // idle low clock gives no false fall
    end else begin
      pin_s1 <= {clear_n_i, load_dac_n_i, frame_sync_n_i,
                 serial_data_in_i, serial_clock_in_i};
      pin_s2 <= pin_s1;
      sclk_d <= sclk_s;
    end
  end

  // frame engine state
  reg [2:0]  state;
  reg [23:0] shift_reg;
  reg [4:0]  bit_cnt;
  reg [3:0]  sync_high_cnt;
  reg        push_valid;
  reg [WORD_W-1:0] push_word;
  reg        overflow;
  reg [15:0] frames_cnt;
  reg [15:0] discard_cnt;
  wire [23:0] next_shift = {shift_reg[22:0], din_s};
  wire        last_bit = (bit_cnt == FRAME_LEN[4:0] - 5'd1);
  wire        fifo_in_ready;
  wire        ovf_clear;

  assign frame_ready_o = fifo_in_ready;

  // serial frame capture; partial frames never reach the fifo
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state         <= ST_IDLE;
      shift_reg     <= 24'h000000;
      bit_cnt       <= 5'h00;
      sync_high_cnt <= 4'h0;
      push_valid    <= 1'b0;
      push_word     <= {WORD_W{1'b0}};
      overflow      <= 1'b0;
      frames_cnt    <= 16'h0000;
      discard_cnt   <= 16'h0000;
    end else begin
      push_valid <= 1'b0;
      // sync high time counted so a short gap does not start a frame
      if (fs_n_s) begin
        if (sync_high_cnt != 4'hF) begin
          sync_high_cnt <= sync_high_cnt + 4'h1;
        end
      end else begin
        sync_high_cnt <= 4'h0;
      end
      // set wins over software clear
      if (push_valid & ~fifo_in_ready) begin
        overflow <= 1'b1;
      end else if (ovf_clear) begin
        overflow <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          // falling sync after enough high time opens a frame
          if (~fs_n_s && sync_high_cnt >= SYNC_MIN[3:0]) begin
            state   <= ST_SHIFT;
            bit_cnt <= 5'h00;
          end
        end
        ST_SHIFT: begin
          if (fs_n_s) begin
            state       <= ST_IDLE;
            discard_cnt <= discard_cnt + 16'h0001;
          end else if (sclk_fall) begin
            shift_reg <= next_shift;
            bit_cnt   <= bit_cnt + 5'h01;
            if (last_bit) begin
              // word handed over on the final falling edge
              state      <= ST_DONE;
              push_valid <= 1'b1;
              frames_cnt <= frames_cnt + 16'h0001;
              if (HIGH_RES) begin
                push_word <= {next_shift[16], next_shift[19:17],
                              next_shift[15:0]};
              end else begin
                push_word <= {next_shift[12], next_shift[15:13],
                              4'h0, next_shift[11:0]};
              end
            end
          end
        end
        ST_DONE: begin
          // extra clocks are ignored until sync returns high
          if (fs_n_s) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // words wait here while software holds the drain stalled
  wire [WORD_W-1:0] pop_word;
  wire              pop_valid;
  wire              pop_ready;
  wire [3:0]        fifo_level;
  reg  [31:0]       ctrl;

  odf_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (`ODF_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (push_word),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (pop_word),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .level_o     (fifo_level)
  );

  assign pop_ready = ~ctrl[`ODF_CTRL_HOLD_BIT];

  // decode of a drained word
  wire       take     = pop_valid & pop_ready;
  wire       word_pd  = pop_word[WORD_W-1];
  wire [2:0] word_ch  = pop_word[WORD_W-2:16];
  wire       clr_now  = ~clr_n_s | ctrl[`ODF_CTRL_CLR_BIT];
  wire       load_now = ~load_n_s;
  reg        power_down;

  // power-down entered by a word with the bit set, left by an update
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      power_down <= 1'b0;
    end else if (take) begin
      power_down <= word_pd;
    end
  end
  assign power_down_o = power_down;

  // eight channels: input register, pending flag, output register
  wire [`ODF_NUM_CHAN-1:0] pend;
  genvar g;
  generate
    for (g = 0; g < `ODF_NUM_CHAN; g = g + 1) begin : g_chan
      reg [15:0] in_q;
      reg [15:0] dac_q;
      reg        pend_q;
      wire       wr = take & ~word_pd & ({29'h0, word_ch} == g);
      always @(posedge core_clk_i) begin
        if (sys_rst_i | clr_now) begin
          in_q   <= `ODF_CODE_RST;
          dac_q  <= `ODF_CODE_RST;
          pend_q <= 1'b0;
        end else begin
          // output moves only while load is held low
          if (load_now & pend_q) begin
            dac_q  <= in_q;
            pend_q <= 1'b0;
          end
          // a new word sets pending even if a transfer clears it now
          if (wr) begin
            in_q   <= pop_word[15:0] & ({16{1'b1}} >> (16 - CODE_W));
            pend_q <= 1'b1;
          end
        end
      end
      assign dac_code_o[g*16 +: 16] = dac_q;
      assign pend[g] = pend_q;
    end
  endgenerate

  // AXI4-Lite write path; address and data taken in either order
  reg        aw_got;
  reg        w_got;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire       aw_hs = s_axi_awvalid & s_axi_awready;
  wire       w_hs  = s_axi_wvalid & s_axi_wready;
  wire       do_wr = aw_got & w_got & ~s_axi_bvalid;
  wire       wr_ctrl = (aw_addr == `ODF_CTRL_OFS);
  wire       wr_stat = (aw_addr == `ODF_STATUS_OFS);

  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
  assign ovf_clear = do_wr & wr_stat & w_strb[0] &
                     w_data[`ODF_ST_OVF_BIT];

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      ctrl         <= `ODF_CTRL_RST;
    end else begin
      if (aw_hs) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // only control and status accept writes; the rest is refused
        s_axi_bresp  <= (wr_ctrl | wr_stat) ? 2'b00 : 2'b10;
        if (wr_ctrl & w_strb[0]) begin
          ctrl[7:0] <= w_data[7:0] & 8'h03;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux over the block's own state
  reg [31:0] rd_val;
  reg        rd_ok;
  always @* begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    if ({s_axi_araddr[11:5], 5'h00} == `ODF_CHAN_BASE_OFS &&
        s_axi_araddr[1:0] == 2'b00) begin
      rd_val[15:0] = dac_code_o[s_axi_araddr[4:2]*16 +: 16];
    end else begin
      case (s_axi_araddr)
        `ODF_CTRL_OFS: begin
          rd_val = ctrl;
        end
        `ODF_STATUS_OFS: begin
          rd_val[`ODF_ST_LEVEL_LSB +: 4] = fifo_level;
          rd_val[`ODF_ST_PD_BIT]         = power_down;
          rd_val[`ODF_ST_OVF_BIT]        = overflow;
          rd_val[`ODF_ST_ACT_BIT]        = (state == ST_SHIFT);
          rd_val[`ODF_ST_PEND_LSB +: 8]  = pend;
        end
        `ODF_FRAMES_OFS: begin
          rd_val[15:0] = frames_cnt;
        end
        `ODF_DISCARD_OFS: begin
          rd_val[15:0] = discard_cnt;
        end
        default: begin
          rd_ok = 1'b0;
        end
      endcase
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;

  // one read in flight; answer registered the edge after the address
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- shared/odf_regs.vh ----
// constants and field layout of the octal converter serial front end
`ifndef ODF_REGS_VH
`define ODF_REGS_VH

// register byte offsets on the AXI4-Lite port
`define ODF_CTRL_OFS       12'h000
`define ODF_STATUS_OFS     12'h004
`define ODF_FRAMES_OFS     12'h008
`define ODF_DISCARD_OFS    12'h00C
`define ODF_CHAN_BASE_OFS  12'h020

// control register fields and reset value
`define ODF_CTRL_HOLD_BIT  0
`define ODF_CTRL_CLR_BIT   1
`define ODF_CTRL_RST       32'h00000000

// status register fields
`define ODF_ST_LEVEL_LSB   0
`define ODF_ST_PD_BIT      4
`define ODF_ST_OVF_BIT     5
`define ODF_ST_ACT_BIT     6
`define ODF_ST_PEND_LSB    8

// frame layout per variant
`define ODF_FRAME_LEN_HI   24
`define ODF_FRAME_LEN_LO   16
`define ODF_CODE_W_HI      16
`define ODF_CODE_W_LO      12
`define ODF_CHAN_W         3
`define ODF_NUM_CHAN       8
`define ODF_CODE_RST       16'h0000

// timing: sync high time between frames
`define ODF_CLK_PERIOD_NS  40
`define ODF_SYNC_HIGH_NS   20
// rounded up, so any nonzero gap needs at least one core cycle
`define ODF_SYNC_HIGH_CYC  ((`ODF_SYNC_HIGH_NS + `ODF_CLK_PERIOD_NS - 1) / \
                            `ODF_CLK_PERIOD_NS)

// fifo depth
`define ODF_FIFO_DEPTH     8

`endif
